// *** dv/latch_side_model.sv ***
module latch_side_model (
    input wire logic clk_i,
    input wire logic present_i,
    input wire logic [31:0] word_i,
    input wire logic [3:0] spoil_i,
    output micro_mem_pkg::latch_word_s latch_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released latches toggle every cycle, so a stale word shows bad parity on every other cycle
    always_ff @(posedge clk_i) begin
        if (present_i) begin
            latch_o.data <= word_i;
            for (int n = 0; n < 4; n++) begin
                latch_o.parity[n] <= ~^word_i[8*n+:8] ^ spoil_i[n];
            end
        end else begin
            latch_o.data <= ~latch_o.data;
            latch_o.parity <= ~latch_o.parity;
        end
    end
endmodule

// *** dv/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic present = 1'b1;
    logic [31:0] word = 32'hA5C31E7F;
    logic [3:0] spoil = 4'h0;
    logic [23:0] xdat = 24'h0;
    logic tape = 1'b0;
    micro_mem_pkg::latch_word_s lat;
    micro_mem_pkg::micro_decode_s dec;
    logic [15:0] mbus, rd;
    logic not8, src, tmode, rsmode, start, hsel, inh, len, strb, mex;
    logic [23:0] stepped, mask, top, xout;
    logic [3:0] pout, pgood;
    int bad_count = 0;
    int checked = 0;
    int start_n = 0;
    int strobe_n = 0;

    always #2.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        start_n <= start_n + int'(start);
        strobe_n <= strobe_n + int'(strb);
    end

    latch_side_model model_u (.clk_i(clk_i), .present_i(present), .word_i(word), .spoil_i(spoil), .latch_o(lat));

    micro_mem_path dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .memory_latch_out_i(lat), .exchange_data_i(xdat), .tape_switch_i(tape), .micro_operator_bus_o(mbus),
        .micro_decode_o(dec), .not_eight_bit_literal_o(not8), .micro_register_source_o(src),
        .maintenance_tape_mode_o(tmode), .run_or_step_mode_o(rsmode), .memory_start_latch_o(start),
        .stepped_address_o(stepped), .read_data_o(rd), .latch_high_select_o(hsel), .latch_low_inhibit_o(inh),
        .latch_low_enable_o(len), .module_parity_out_o(pout), .module_parity_good_o(pgood),
        .mask_generate_o(mask), .x_top_bit_o(top), .mask_strobe_second_o(strb), .exchange_o(xout),
        .exchange_from_info_reg_o(mex));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic cycle; the answer is taken only at the edge that shows ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        r = rdat;
        chk("ack_wait", 2, n);
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
        wait_cyc(2);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(what, exp, r);
    endtask

    task automatic move_micro(input logic [15:0] m);
        @(posedge clk_i);
        xdat <= {8'h00, m};
        wr(micro_mem_pkg::ADR_CMD, 32'h2);
    endtask

    task automatic t_reset();
        chk("not8", 1, not8);
        chk("inhibit", 1, inh);
        chk("stepped", 24'h000001, stepped);
        chk("mask", 24'hFFFFFF, mask);
        chk("top", 24'h800000, top);
        chk("run_step", 1, rsmode);
        chk("parity_out", 4'hF, pout);
        rdchk("field_len", micro_mem_pkg::ADR_FLEN, 32'h18);
        rdchk("unmapped", 8'h3C, 32'h0);
        $display("done reset");
    endtask

    task automatic t_step();
        wr(micro_mem_pkg::ADR_MAR, 32'h00FFFF);
        rdchk("mar", micro_mem_pkg::ADR_MAR, 32'h00FFFF);
        chk("step_up", 24'h010000, stepped);
        wr(micro_mem_pkg::ADR_CTRL, 32'h4);
        chk("step_down", 24'h00FFFE, stepped);
        $display("done step");
    endtask

    task automatic t_latch();
        wr(micro_mem_pkg::ADR_CTRL, 32'h2);
        chk("low_read", 16'h1E7F, rd);
        chk("low_en", 1, len);
        wr(micro_mem_pkg::ADR_CTRL, 32'h1);
        chk("high_read", 16'hA5C3, rd);
        chk("high_inh", 3'b100, {hsel, inh, len});
        wr(micro_mem_pkg::ADR_CTRL, 32'h3);
        chk("both_read", 16'hA5C3, rd);
        chk("both_low", 0, len);
        chk("good", 4'hF, pgood);
        @(posedge clk_i);
        spoil <= 4'b0100;
        wait_cyc(5);
        chk("bad_mod2", 4'b1011, pgood);
        wr(micro_mem_pkg::ADR_CMD, 32'h4);
        chk("from_latch", 16'hA5C3, mbus);
        $display("done latch");
    endtask

    task automatic t_decode();
        logic [15:0] ops[6] = '{16'h01F0, 16'h03F0, 16'h04D0, 16'h05D0, 16'h06D0, 16'h07D0};
        logic [15:0] lits[4] = '{16'h8012, 16'h1123, 16'h2000, 16'h3000};
        logic [1:0] lx[4] = '{2'b01, 2'b11, 2'b11, 2'b10};
        for (int i = 0; i < 6; i++) begin
            move_micro(ops[i]);
            chk("micro_bus", ops[i], mbus);
            chk("decode", 6'b100000 >> i, dec);
        end
        for (int i = 0; i < 4; i++) begin
            move_micro(lits[i]);
            chk("literal", lx[i], {not8, src});
            chk("no_decode", 0, dec);
        end
        $display("done decode");
    endtask

    task automatic t_tape();
        @(posedge clk_i);
        tape <= 1'b1;
        wait_cyc(5);
        chk("tape_lvl", 2'b10, {tmode, rsmode});
        move_micro(16'h0123);
        chk("blocked", 16'h3000, mbus);
        @(posedge clk_i);
        tape <= 1'b0;
        wait_cyc(5);
        chk("run_lvl", 2'b01, {tmode, rsmode});
        move_micro(16'h0123);
        chk("moved", 16'h0123, mbus);
        $display("done tape");
    endtask

    task automatic t_start();
        int s0;
        move_micro(16'h7000);
        s0 = start_n;
        wr(micro_mem_pkg::ADR_CMD, 32'h1);
        wr(micro_mem_pkg::ADR_CMD, 32'h1);
        wait_cyc(60);
        chk("start_len", micro_mem_pkg::START_CYCLES, start_n - s0);
        move_micro(16'h3000);
        wr(micro_mem_pkg::ADR_CMD, 32'h1);
        wait_cyc(5);
        chk("no_start", micro_mem_pkg::START_CYCLES, start_n - s0);
        $display("done start");
    endtask

    task automatic t_mir();
        int s0 = strobe_n;
        wr(micro_mem_pkg::ADR_FLEN, 32'h10);
        @(posedge clk_i);
        xdat <= 24'hAB1234;
        wr(micro_mem_pkg::ADR_CMD, 32'h8);
        chk("strobe", 1, strobe_n - s0);
        rdchk("mir", micro_mem_pkg::ADR_MIR, 32'h001234);
        chk("mask16", 24'h00FFFF, mask);
        chk("top16", 24'h008000, top);
        chk("parity", 4'b1110, pout);
        wr(micro_mem_pkg::ADR_CTRL, 32'h8);
        chk("exchange", 24'h001234, xout);
        chk("mex", 1, mex);
        wr(micro_mem_pkg::ADR_CTRL, 32'hB);
        wr(micro_mem_pkg::ADR_CMD, 32'h10);
        chk("strobe_capt", 2, strobe_n - s0);
        chk("exchange_capt", 24'h00A5C3, xout);
        chk("parity_capt", 4'hF, pout);
        rdchk("mir_capt", micro_mem_pkg::ADR_MIR, 32'h00A5C3);
        $display("done mir");
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_cyc(5);
        t_reset();
        t_step();
        t_latch();
        t_decode();
        t_tape();
        t_start();
        t_mir();
        summarize();
    end
endmodule

// *** rtl/micro_mem_path.sv ***
module micro_mem_path (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire micro_mem_pkg::latch_word_s memory_latch_out_i,
    input wire logic [23:0] exchange_data_i,
    input wire logic tape_switch_i,
    output logic [15:0] micro_operator_bus_o,
    output micro_mem_pkg::micro_decode_s micro_decode_o,
    output logic not_eight_bit_literal_o,
    output logic micro_register_source_o,
    output logic maintenance_tape_mode_o,
    output logic run_or_step_mode_o,
    output logic memory_start_latch_o,
    output logic [23:0] stepped_address_o,
    output logic [15:0] read_data_o,
    output logic latch_high_select_o,
    output logic latch_low_inhibit_o,
    output logic latch_low_enable_o,
    output logic [3:0] module_parity_out_o,
    output logic [3:0] module_parity_good_o,
    output logic [23:0] mask_generate_o,
    output logic [23:0] x_top_bit_o,
    output logic mask_strobe_second_o,
    output logic [23:0] exchange_o,
    output logic exchange_from_info_reg_o
);
    localparam int START_LEN = micro_mem_pkg::START_CYCLES;

    function automatic logic op_is(input logic [15:0] m, input logic [3:0] dig, input logic [3:0] fam);
        op_is = (m[15:12] == micro_mem_pkg::OP_FAMILY) && (m[11:8] == dig) && (m[7:4] == fam);
    endfunction

    micro_mem_pkg::latch_word_s latch_a;
    micro_mem_pkg::latch_word_s latch_s;
    logic tape_a;
    logic tape_s;
    logic [3:0] ctrl;
    logic [23:0] memory_address_register;
    logic [4:0] field_len;
    logic [15:0] micro;
    logic [23:0] mir;
    logic [5:0] start_cnt;

    // Bus decode
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire hit_ctrl = (wb_adr_i == micro_mem_pkg::ADR_CTRL);
    wire hit_cmd = (wb_adr_i == micro_mem_pkg::ADR_CMD);
    wire hit_mar = (wb_adr_i == micro_mem_pkg::ADR_MAR);
    wire hit_field_len = (wb_adr_i == micro_mem_pkg::ADR_FLEN);
    wire wr_lane0 = wb_wr & wb_sel_i[0];
    wire [4:0] cmd = (wr_lane0 & hit_cmd) ? wb_dat_i[4:0] : 5'h00;
    wire cmd_exec = cmd[micro_mem_pkg::CMD_EXEC];
    wire cmd_move = cmd[micro_mem_pkg::CMD_MOVE];
    wire cmd_latch = cmd[micro_mem_pkg::CMD_LATCH];
    wire cmd_strobe = cmd[micro_mem_pkg::CMD_STROBE];
    wire cmd_capt = cmd[micro_mem_pkg::CMD_CAPT];
    wire [23:0] next_mar = {
        wb_sel_i[2] ? wb_dat_i[23:16] : memory_address_register[23:16],
        wb_sel_i[1] ? wb_dat_i[15:8] : memory_address_register[15:8],
        wb_sel_i[0] ? wb_dat_i[7:0] : memory_address_register[7:0]
    };

    // Latch selection; high half wins so the two paths never overlap
    wire high_sel = ctrl[micro_mem_pkg::CTRL_HIGH];
    wire low_inhibit = ~high_sel;
    wire low_en = ctrl[micro_mem_pkg::CTRL_LOW] & low_inhibit;
    wire [15:0] next_read =
        high_sel ? latch_s.data[31:16] :
        low_en ? latch_s.data[15:0] : 16'h0000;

    wire tape_mode_dest_block = tape_s;
    wire micro_register_dest = cmd_move & ~tape_mode_dest_block;
    wire micro_register_from_latches = cmd_latch & ~micro_register_dest;
    wire is_mem_micro = (micro[15:12] == micro_mem_pkg::OP_MEM);
    wire memory_start_set = cmd_exec & is_mem_micro & ~memory_start_latch_o;

    wire [23:0] next_mask = (field_len >= micro_mem_pkg::FLEN_FULL) ? 24'hFFFFFF :
        24'((25'h0000001 << field_len) - 25'h0000001);
    wire [23:0] next_top = (field_len == 5'h00) ? 24'h000000 :
        (field_len >= micro_mem_pkg::FLEN_FULL) ? 24'h800000 : 24'(25'h0000001 << (field_len - 5'h01));
    wire [23:0] next_step = ctrl[micro_mem_pkg::CTRL_DOWN] ? (memory_address_register - 24'h000001) : (memory_address_register + 24'h000001);
    wire [31:0] write_word = {8'h00, mir};
    wire [31:0] status = {8'h00, micro_register_source_o, not_eight_bit_literal_o, tape_s,
        memory_start_latch_o, module_parity_good_o, micro};
    wire [31:0] next_rdata =
        (wb_adr_i == micro_mem_pkg::ADR_CTRL) ? {28'h0000000, ctrl} :
        (wb_adr_i == micro_mem_pkg::ADR_MAR) ? {8'h00, memory_address_register} :
        (wb_adr_i == micro_mem_pkg::ADR_FLEN) ? {27'h0000000, field_len} :
        (wb_adr_i == micro_mem_pkg::ADR_STATUS) ? status :
        (wb_adr_i == micro_mem_pkg::ADR_MIR) ? {8'h00, mir} :
        (wb_adr_i == micro_mem_pkg::ADR_READ) ? {16'h0000, read_data_o} : 32'h00000000;

    wire micro_mem_pkg::micro_decode_s next_decode;
    assign next_decode.halt = op_is(micro, micro_mem_pkg::DIG_HALT, micro_mem_pkg::FAM_F);
    assign next_decode.normalize_x = op_is(micro, micro_mem_pkg::DIG_NORM, micro_mem_pkg::FAM_F);
    assign next_decode.shift_rotate = op_is(micro, micro_mem_pkg::DIG_SHIFT, micro_mem_pkg::FAM_D);
    assign next_decode.shift_pair = op_is(micro, micro_mem_pkg::DIG_PAIR, micro_mem_pkg::FAM_D);
    assign next_decode.count_field = op_is(micro, micro_mem_pkg::DIG_COUNT, micro_mem_pkg::FAM_D);
    assign next_decode.exchange_doublepad = op_is(micro, micro_mem_pkg::DIG_XCHG, micro_mem_pkg::FAM_D);

    // Latch and tape switch pins pass two stages before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_a <= '0;
            latch_s <= '0;
            tape_a <= 1'b0;
            tape_s <= 1'b0;
        end else if (ce_i) begin
            latch_a <= memory_latch_out_i;
            latch_s <= latch_a;
            tape_a <= tape_switch_i;
            tape_s <= tape_a;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= micro_mem_pkg::CTRL_RST;
            memory_address_register <= micro_mem_pkg::MAR_RST;
            field_len <= micro_mem_pkg::FLEN_RST;
        end else if (ce_i) begin
            if (wr_lane0 && hit_ctrl) begin
                ctrl <= wb_dat_i[3:0];
            end
            if (wb_wr && hit_mar) begin
                memory_address_register <= next_mar;
            end
            if (wr_lane0 && hit_field_len) begin
                field_len <= wb_dat_i[4:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            micro <= micro_mem_pkg::MICRO_RST;
        end else if (ce_i) begin
            if (micro_register_dest) begin
                micro <= exchange_data_i[15:0];
            end else if (micro_register_from_latches) begin
                micro <= read_data_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memory_start_latch_o <= 1'b0;
            start_cnt <= 6'h00;
        end else if (ce_i) begin
            if (memory_start_set) begin
                memory_start_latch_o <= 1'b1;
                start_cnt <= 6'(START_LEN - 1);
            end else if (memory_start_latch_o) begin
                memory_start_latch_o <= (start_cnt != 6'h00);
                start_cnt <= start_cnt - 6'h01;
            end
        end
    end

    // Strobe from the exchange wins over a capture of read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mir <= 24'h000000;
            mask_strobe_second_o <= 1'b0;
        end else if (ce_i) begin
            mask_strobe_second_o <= cmd_strobe | cmd_capt;
            if (cmd_strobe) begin
                mir <= exchange_data_i & mask_generate_o;
            end else if (cmd_capt) begin
                mir <= {8'h00, read_data_o};
            end
        end
    end

    // Per-module terms are nets so each bit has its own single driver
    wire [3:0] next_parity_out;
    wire [3:0] next_parity_good;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_parity
            assign next_parity_out[g] = ~^write_word[8*g +: 8];
            assign next_parity_good[g] = ^{latch_s.data[8*g +: 8], latch_s.parity[g]};
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_parity_out_o <= 4'hF;
            module_parity_good_o <= 4'h0;
        end else if (ce_i) begin
            module_parity_out_o <= next_parity_out;
            module_parity_good_o <= next_parity_good;
        end
    end

    // Decodes lag the micro register by one cycle to stay registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            micro_decode_o <= '0;
            not_eight_bit_literal_o <= 1'b1;
            micro_register_source_o <= 1'b0;
            maintenance_tape_mode_o <= 1'b0;
            run_or_step_mode_o <= 1'b1;
        end else if (ce_i) begin
            micro_decode_o <= next_decode;
            not_eight_bit_literal_o <= (micro[15:12] != micro_mem_pkg::OP_LIT8);
            micro_register_source_o <= (micro[15:12] == micro_mem_pkg::OP_LIT1) ||
                (micro[15:12] == micro_mem_pkg::OP_LIT2) || (micro[15:12] == micro_mem_pkg::OP_LIT8);
            maintenance_tape_mode_o <= tape_s;
            run_or_step_mode_o <= ~tape_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_data_o <= 16'h0000;
            latch_high_select_o <= 1'b0;
            latch_low_inhibit_o <= 1'b1;
            latch_low_enable_o <= 1'b0;
            stepped_address_o <= 24'h000001;
            mask_generate_o <= 24'hFFFFFF;
            x_top_bit_o <= 24'h800000;
            exchange_o <= 24'h000000;
            exchange_from_info_reg_o <= 1'b0;
        end else if (ce_i) begin
            read_data_o <= next_read;
            latch_high_select_o <= high_sel;
            latch_low_inhibit_o <= low_inhibit;
            latch_low_enable_o <= low_en;
            stepped_address_o <= next_step;
            mask_generate_o <= next_mask;
            x_top_bit_o <= next_top;
            exchange_from_info_reg_o <= ctrl[micro_mem_pkg::CTRL_MEX];
            exchange_o <= ctrl[micro_mem_pkg::CTRL_MEX] ? (mir & mask_generate_o) : 24'h000000;
        end
    end

    assign micro_operator_bus_o = micro;

    // Helper: counts cycles of the start pulse
    logic [7:0] start_len;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_len <= 8'h00;
        end else if (ce_i) begin
            start_len <= memory_start_latch_o ? start_len + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_latch_exclusive: assert property (!(latch_high_select_o && latch_low_enable_o))
        else $error("both latch halves enabled");
    a_inhibit_high: assert property (latch_high_select_o |-> !latch_low_inhibit_o)
        else $error("low inhibit high during high select");
    a_high_data: assert property (ce_i && high_sel |=> read_data_o == $past(latch_s.data[31:16]))
        else $error("high half data wrong");
    a_low_data: assert property (ce_i && low_en |=> read_data_o == $past(latch_s.data[15:0]))
        else $error("low half data wrong");
    a_start_width: assert property ($fell(memory_start_latch_o) |-> start_len == START_LEN)
        else $error("start pulse width wrong");
    a_start_cause: assert property ($rose(memory_start_latch_o) |-> $past(cmd_exec && is_mem_micro))
        else $error("start without memory micro");
    a_step_addr: assert property (ce_i ##1 ce_i |-> stepped_address_o == $past(next_step))
        else $error("stepped address wrong");
    a_move_load: assert property (ce_i && cmd_move && !tape_s |=> micro == $past(exchange_data_i[15:0]))
        else $error("micro not loaded from exchange");
    a_tape_block: assert property (ce_i && tape_s && !cmd_latch |=> micro == $past(micro))
        else $error("micro changed in tape mode");
    a_mode_levels: assert property (maintenance_tape_mode_o != run_or_step_mode_o)
        else $error("mode levels not complementary");
    a_decode_onehot: assert property ($onehot0(micro_decode_o))
        else $error("more than one decode");
    a_halt_decode: assert property (ce_i && micro == 16'h01F0 |=> micro_decode_o.halt)
        else $error("halt not decoded");
    a_parity_gen: assert property (ce_i |=> ^{module_parity_out_o[0], $past(write_word[7:0])})
        else $error("module 0 parity not odd");
    a_mask_strobe: assert property (ce_i && (cmd_strobe || cmd_capt) |=> mask_strobe_second_o)
        else $error("mask strobe missing");
    a_norm_decode: assert property (ce_i && micro == 16'h03F0 |=> micro_decode_o.normalize_x)
        else $error("normalize not decoded");
    a_shift_decode: assert property (ce_i && micro == 16'h04D0 |=> micro_decode_o.shift_rotate)
        else $error("shift or rotate not decoded");
    a_pair_decode: assert property (ce_i && micro == 16'h05D0 |=> micro_decode_o.shift_pair)
        else $error("shift pair not decoded");
    a_count_decode: assert property (ce_i && micro == 16'h06D0 |=> micro_decode_o.count_field)
        else $error("count field not decoded");
    a_xchg_decode: assert property (ce_i && micro == 16'h07D0 |=> micro_decode_o.exchange_doublepad)
        else $error("doublepad exchange not decoded");
    a_not8_flag: assert property (ce_i && micro[15:12] == micro_mem_pkg::OP_LIT8
        |=> !not_eight_bit_literal_o) else $error("literal flag wrong");
    a_exchange_mir: assert property (ce_i && ctrl[micro_mem_pkg::CTRL_MEX]
        |=> exchange_o == $past(mir & mask_generate_o)) else $error("exchange not from info register");
    a_latch_load: assert property (ce_i && cmd_latch && !cmd_move |=> micro == $past(read_data_o))
        else $error("micro not loaded from latches");
    a_parity_check: assert property (ce_i
        |=> module_parity_good_o[0] == $past(^{latch_s.data[7:0], latch_s.parity[0]}))
        else $error("module 0 parity check wrong");

    c_start: cover property ($fell(memory_start_latch_o));
    c_tape_block: cover property (tape_s && cmd_move);
    c_mir_out: cover property (mask_strobe_second_o ##1 exchange_from_info_reg_o);
    c_latch_load: cover property (micro_register_from_latches);
    c_decode_halt: cover property (micro_decode_o.halt);
endmodule

// *** shared/micro_mem_pkg.sv ***
package micro_mem_pkg;
    localparam int CLK_MHZ = 200;
    localparam int START_NS = 250;
    localparam int START_CYCLES = (START_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_MAR = 8'h08;
    localparam logic [7:0] ADR_FLEN = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_MIR = 8'h14;
    localparam logic [7:0] ADR_READ = 8'h18;
    localparam int CTRL_HIGH = 0;
    localparam int CTRL_LOW = 1;
    localparam int CTRL_DOWN = 2;
    localparam int CTRL_MEX = 3;
    localparam int CMD_EXEC = 0;
    localparam int CMD_MOVE = 1;
    localparam int CMD_LATCH = 2;
    localparam int CMD_STROBE = 3;
    localparam int CMD_CAPT = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [23:0] MAR_RST = 24'h000000;
    localparam logic [4:0] FLEN_RST = 5'h18;
    localparam logic [15:0] MICRO_RST = 16'h0000;
    localparam logic [4:0] FLEN_FULL = 5'h18;
    localparam logic [3:0] OP_FAMILY = 4'h0;
    localparam logic [3:0] OP_LIT1 = 4'h1;
    localparam logic [3:0] OP_LIT2 = 4'h2;
    localparam logic [3:0] OP_MEM = 4'h7;
    localparam logic [3:0] OP_LIT8 = 4'h8;
    localparam logic [3:0] FAM_D = 4'hD;
    localparam logic [3:0] FAM_F = 4'hF;
    localparam logic [3:0] DIG_HALT = 4'h1;
    localparam logic [3:0] DIG_NORM = 4'h3;
    localparam logic [3:0] DIG_SHIFT = 4'h4;
    localparam logic [3:0] DIG_PAIR = 4'h5;
    localparam logic [3:0] DIG_COUNT = 4'h6;
    localparam logic [3:0] DIG_XCHG = 4'h7;

    typedef struct packed {
        logic halt;
        logic normalize_x;
        logic shift_rotate;
        logic shift_pair;
        logic count_field;
        logic exchange_doublepad;
    } micro_decode_s;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] parity;
    } latch_word_s;
endpackage
